// [rtcnp_assertions.sv]
/*
  Pin-level checker for the nibble port, watching the carrier signals.
  Assumes one clock, synchronous active-high reset, TONE_HALF as given
  to the device end.
*/
`timescale 1ns/1ns
module rtcnp_assertions #(
    parameter int TONE_HALF = 4
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cs_low_w,
    input wire logic cs_high_w,
    input wire logic clock_out_select_pin,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic clock_out_out,
    input wire logic clock_out_oe_n,
    input wire logic alarm_irq_out,
    input wire logic alarm_irq_oe_n,
    input wire logic timer_irq_out,
    input wire logic timer_irq_oe_n
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ---------------------------------------------------------------
    // Helper logic
    // ---------------------------------------------------------------
    logic sel_rd;
    logic fixed_w;
    logic fixed_r;
    logic armed_r;
    logic [15:0] half_cnt_r;
    assign sel_rd = !cs_low_w && cs_high_w && !read_strobe_n && write_strobe_n;
    assign fixed_w = !clock_out_oe_n && !clock_out_select_pin && cs_high_w;

    // Armed only after a full edge seen in fixed mode, so entry phase is ignored
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            half_cnt_r <= 16'h0000;
            fixed_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            half_cnt_r <= $changed(clock_out_out) ? 16'h0000 : half_cnt_r + 16'h0001;
            fixed_r <= fixed_w;
            armed_r <= fixed_w && fixed_r && (armed_r || $changed(clock_out_out));
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sel_access_a: assert property ((!read_strobe_n || !write_strobe_n) |-> (!cs_low_w && cs_high_w))
        else $error("strobe outside select");
    rd_drive_on_a: assert property (sel_rd |=> !dev_data_oe_n)
        else $error("selected read not driven");
    rd_drive_only_a: assert property (!dev_data_oe_n |-> $past(sel_rd))
        else $error("data driven outside read");
    bus_no_fight_a: assert property (!(!dev_data_oe_n && !host_data_oe_n))
        else $error("data bus contention");
    strobe_excl_a: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low");
    clk_float_a: assert property (!cs_high_w |=> clock_out_oe_n)
        else $error("clock output driven while deselected");
    clk_fixed_on_a: assert property (cs_high_w && !clock_out_select_pin |=> !clock_out_oe_n)
        else $error("fixed tone not driven");
    tone_half_a: assert property (armed_r && fixed_w && $changed(clock_out_out) |-> half_cnt_r == TONE_HALF - 1)
        else $error("tone half period wrong");
    alarm_low_only_a: assert property (!alarm_irq_oe_n |-> !alarm_irq_out)
        else $error("alarm output driven high");
    timer_low_only_a: assert property (!timer_irq_oe_n |-> !timer_irq_out)
        else $error("timer output driven high");

    rd_seen_c: cover property (sel_rd ##1 !dev_data_oe_n);
    tone_seen_c: cover property (armed_r && $changed(clock_out_out));
    alarm_seen_c: cover property (!alarm_irq_oe_n);
    timer_seen_c: cover property (!timer_irq_oe_n);
endmodule

// [rtcnp_dev.sv]
/*
  Device end of the nibble-wide host port: chip-select decode, a sixteen
  nibble register file, clock output gating and two open-drain interrupts.
  Assumes pins are synchronous to clk_i and the host keeps its strobes
  apart; alarm and timer events arrive as one-cycle pulses.
*/
`timescale 1ns/1ns
module rtcnp_dev #(
    parameter int TONE_HALF = rtcnp_pkg::TONE_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    rtcnp_if.dev bus,
    input wire logic alarm_event_i,
    input wire logic timer_event_i,
    output logic selected_o,
    output logic access_error_o,
    output logic clk_out_enable_o
);

    // ---------------------------------------------------------------
    // Address match helper
    // ---------------------------------------------------------------
    function automatic logic addr_hit(
        input logic [rtcnp_pkg::ADDR_W-1:0] addr,
        input logic [rtcnp_pkg::ADDR_W-1:0] idx
    );
        addr_hit = (addr == idx);
    endfunction

    // ---------------------------------------------------------------
    // Access decode
    // ---------------------------------------------------------------
    logic sel_w;
    logic rd_w;
    logic wr_w;
    logic err_w;

    assign sel_w = !bus.cs_low_w && bus.cs_high_w;
    assign rd_w = sel_w && !bus.read_strobe_n && bus.write_strobe_n;
    assign wr_w = sel_w && !bus.write_strobe_n && bus.read_strobe_n;
    // Both strobes low: nothing stored, nothing driven
    assign err_w = sel_w && !bus.read_strobe_n && !bus.write_strobe_n;

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [rtcnp_pkg::DATA_W-1:0] mem_r [rtcnp_pkg::REG_NUM];
    logic [rtcnp_pkg::DATA_W-1:0] flag_r;
    logic [rtcnp_pkg::DATA_W-1:0] flag_nxt;
    logic [rtcnp_pkg::DATA_W-1:0] flag_clr_w;
    logic [rtcnp_pkg::DATA_W-1:0] flag_set_w;
    logic flag_wr_w;

    genvar gi;
    generate
        for (gi = 0; gi < rtcnp_pkg::REG_NUM; gi++)
        begin : g_reg
            logic hit_w;
            assign hit_w = wr_w && addr_hit(bus.reg_addr_in, 4'(gi));
            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                begin
                    mem_r[gi] <= rtcnp_pkg::REG_RESET;
                end
                else if (hit_w)
                begin
                    mem_r[gi] <= bus.nibble_data_io;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Event flags: write one to clear, a new event wins
    // ---------------------------------------------------------------
    assign flag_wr_w = wr_w && addr_hit(bus.reg_addr_in, rtcnp_pkg::FLAG_ADDR);
    assign flag_clr_w = flag_wr_w ? bus.nibble_data_io : 4'h0;
    assign flag_set_w = {2'b00, timer_event_i, alarm_event_i};
    assign flag_nxt = (flag_r & ~flag_clr_w) | flag_set_w;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            flag_r <= rtcnp_pkg::REG_RESET;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    logic [rtcnp_pkg::DATA_W-1:0] rd_sel_w;
    logic [rtcnp_pkg::DATA_W-1:0] data_r;
    logic data_oe_n_r;

    // Flag register reads live flags; the stored copy is unused there
    assign rd_sel_w = addr_hit(bus.reg_addr_in, rtcnp_pkg::FLAG_ADDR) ?
                      flag_r : mem_r[bus.reg_addr_in];

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            data_r <= rtcnp_pkg::REG_RESET;
            data_oe_n_r <= 1'b1;
        end
        else
        begin
            data_r <= rd_sel_w;
            data_oe_n_r <= !rd_w;
        end
    end

    assign bus.dev_data_out = data_r;
    assign bus.dev_data_oe_n = data_oe_n_r;

    // ---------------------------------------------------------------
    // Tone generator and prescaler
    // ---------------------------------------------------------------
    // Integer divide: 125 MHz does not split evenly, tone is ~0.02% fast
    localparam logic [rtcnp_pkg::TONE_CNT_W-1:0] HALF_LAST =
        rtcnp_pkg::TONE_CNT_W'(TONE_HALF - 1);

    logic [rtcnp_pkg::TONE_CNT_W-1:0] tone_cnt_r;
    logic tone_r;
    logic [rtcnp_pkg::PRE_W-1:0] pre_r;
    logic tone_wrap_w;

    assign tone_wrap_w = (tone_cnt_r == HALF_LAST);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            tone_cnt_r <= '0;
            tone_r <= 1'b0;
            pre_r <= '0;
        end
        else
        begin
            tone_cnt_r <= tone_wrap_w ? '0 : tone_cnt_r + 1'b1;
            if (tone_wrap_w)
            begin
                tone_r <= !tone_r;
            end
            if (tone_wrap_w && !tone_r)
            begin
                pre_r <= pre_r + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Clock output selection and gating
    // ---------------------------------------------------------------
    logic [rtcnp_pkg::DATA_W-1:0] ctrl_w;
    logic out_enable_flag;
    logic [rtcnp_pkg::FD_W-1:0] out_freq_field;
    logic chosen_w;
    logic fo_drive_w;
    logic fo_value_w;
    logic fo_r;
    logic fo_oe_n_r;

    assign ctrl_w = mem_r[rtcnp_pkg::CTRL_ADDR];
    assign out_enable_flag = ctrl_w[rtcnp_pkg::CTRL_EN_BIT];
    assign out_freq_field = ctrl_w[rtcnp_pkg::CTRL_FD_LSB +: rtcnp_pkg::FD_W];

    // 32768 Hz, 1024 Hz, 32 Hz, 1 Hz
    assign chosen_w = (out_freq_field == 2'd0) ? tone_r :
                      (out_freq_field == 2'd1) ? pre_r[4] :
                      (out_freq_field == 2'd2) ? pre_r[9] : pre_r[14];

    // Low chip select plays no part here
    assign fo_drive_w = bus.cs_high_w &&
                        (!bus.clock_out_select_pin || out_enable_flag);
    assign fo_value_w = bus.clock_out_select_pin ? chosen_w : tone_r;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            fo_r <= 1'b0;
            fo_oe_n_r <= 1'b1;
        end
        else
        begin
            fo_r <= fo_value_w;
            fo_oe_n_r <= !fo_drive_w;
        end
    end

    assign bus.clock_out_out = fo_r;
    assign bus.clock_out_oe_n = fo_oe_n_r;

    // ---------------------------------------------------------------
    // Open-drain interrupts
    // ---------------------------------------------------------------
    logic [rtcnp_pkg::DATA_W-1:0] mask_w;
    logic airq_oe_n_r;
    logic tirq_oe_n_r;
    logic irq_low_r;

    assign mask_w = mem_r[rtcnp_pkg::MASK_ADDR];

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            airq_oe_n_r <= 1'b1;
            tirq_oe_n_r <= 1'b1;
            irq_low_r <= 1'b0;
        end
        else
        begin
            airq_oe_n_r <= !(flag_r[rtcnp_pkg::ALARM_BIT] && mask_w[rtcnp_pkg::ALARM_BIT]);
            tirq_oe_n_r <= !(flag_r[rtcnp_pkg::TIMER_BIT] && mask_w[rtcnp_pkg::TIMER_BIT]);
            irq_low_r <= 1'b0;
        end
    end

    // Drive value is always low: enabling the pin can only pull it down
    assign bus.alarm_irq_out = irq_low_r;
    assign bus.timer_irq_out = irq_low_r;
    assign bus.alarm_irq_oe_n = airq_oe_n_r;
    assign bus.timer_irq_oe_n = tirq_oe_n_r;

    // ---------------------------------------------------------------
    // Status outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            selected_o <= 1'b0;
            access_error_o <= 1'b0;
            clk_out_enable_o <= 1'b0;
        end
        else
        begin
            selected_o <= sel_w;
            access_error_o <= err_w;
            clk_out_enable_o <= fo_drive_w;
        end
    end

endmodule

// [rtcnp_host.sv]
/*
  Host end of the nibble-wide port: turns one user request into a
  select, strobe and release sequence on the pins.
  Assumes the device answers a read within one cycle of the strobe.
*/
`timescale 1ns/1ns
module rtcnp_host (
    input wire logic clk_i,
    input wire logic reset_i,
    rtcnp_if.host bus,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [rtcnp_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [rtcnp_pkg::DATA_W-1:0] req_wdata_i,
    input wire logic clk_out_on_i,
    input wire logic fixed_tone_i,
    output logic ready_o,
    output logic done_o,
    output logic [rtcnp_pkg::DATA_W-1:0] rdata_o,
    output logic alarm_irq_o,
    output logic timer_irq_o
);

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    localparam logic [rtcnp_pkg::STROBE_CNT_W-1:0] STROBE_LAST =
        rtcnp_pkg::STROBE_CNT_W'(rtcnp_pkg::STROBE_CYC - 1);

    rtcnp_pkg::rtcnp_hstate_e st_r;
    rtcnp_pkg::rtcnp_hstate_e st_nxt;
    logic [rtcnp_pkg::STROBE_CNT_W-1:0] cnt_r;
    logic wr_r;
    logic [rtcnp_pkg::ADDR_W-1:0] addr_r;
    logic [rtcnp_pkg::DATA_W-1:0] wdata_r;
    logic strobe_end_w;

    assign strobe_end_w = (cnt_r == STROBE_LAST);

    always_comb
    begin
        case (st_r)
            rtcnp_pkg::HS_IDLE: st_nxt = req_i ? rtcnp_pkg::HS_SETUP : rtcnp_pkg::HS_IDLE;
            rtcnp_pkg::HS_SETUP: st_nxt = rtcnp_pkg::HS_STROBE;
            rtcnp_pkg::HS_STROBE: st_nxt = strobe_end_w ? rtcnp_pkg::HS_HOLD : rtcnp_pkg::HS_STROBE;
            rtcnp_pkg::HS_HOLD: st_nxt = rtcnp_pkg::HS_DONE;
            rtcnp_pkg::HS_DONE: st_nxt = rtcnp_pkg::HS_IDLE;
            default: st_nxt = rtcnp_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_r <= rtcnp_pkg::HS_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= (st_r == rtcnp_pkg::HS_STROBE) ? cnt_r + 1'b1 : '0;
            if (st_r == rtcnp_pkg::HS_IDLE && req_i)
            begin
                wr_r <= req_write_i;
                addr_r <= req_addr_i;
                wdata_r <= req_wdata_i;
            end
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    logic busy_w;
    logic strobing_w;
    logic cs_low_n_r;
    logic cs_high_r;
    logic rd_n_r;
    logic wr_n_r;
    logic dat_oe_n_r;
    logic sel_pin_r;

    assign busy_w = (st_nxt == rtcnp_pkg::HS_SETUP) || (st_nxt == rtcnp_pkg::HS_STROBE) ||
                    (st_nxt == rtcnp_pkg::HS_HOLD);
    assign strobing_w = (st_nxt == rtcnp_pkg::HS_STROBE);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cs_low_n_r <= 1'b1;
            cs_high_r <= 1'b0;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            dat_oe_n_r <= 1'b1;
            sel_pin_r <= 1'b1;
        end
        else
        begin
            cs_low_n_r <= !busy_w;
            cs_high_r <= busy_w || clk_out_on_i;
            // Only one strobe can be low at a time
            rd_n_r <= !(strobing_w && !wr_r);
            wr_n_r <= !(strobing_w && wr_r);
            dat_oe_n_r <= !(busy_w && wr_r);
            sel_pin_r <= !fixed_tone_i;
        end
    end

    assign bus.chip_select_low_active_n = cs_low_n_r;
    assign bus.chip_select_high_active = cs_high_r;
    assign bus.cs_oe_n = 1'b0;
    assign bus.read_strobe_n = rd_n_r;
    assign bus.write_strobe_n = wr_n_r;
    assign bus.reg_addr_in = addr_r;
    assign bus.host_data_out = wdata_r;
    assign bus.host_data_oe_n = dat_oe_n_r;
    assign bus.clock_out_select_pin = sel_pin_r;

    // ---------------------------------------------------------------
    // User side
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ready_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
            alarm_irq_o <= 1'b0;
            timer_irq_o <= 1'b0;
        end
        else
        begin
            ready_o <= (st_nxt == rtcnp_pkg::HS_IDLE);
            done_o <= (st_r == rtcnp_pkg::HS_HOLD);
            if (st_r == rtcnp_pkg::HS_STROBE && strobe_end_w && !wr_r)
            begin
                rdata_o <= bus.nibble_data_io;
            end
            alarm_irq_o <= !bus.alarm_irq_n;
            timer_irq_o <= !bus.timer_irq_n;
        end
    end

endmodule

// [rtcnp_if.sv]
/*
  Pin-level carrier between the host end and the device end.
  Assumes chip selects, data, clock output and interrupts are driven as value plus active-low enable; the
  resolved levels, pull-ups and pull-downs are worked out here.
*/
`timescale 1ns/1ns
interface rtcnp_if;
    // Host-driven pins
    logic chip_select_low_active_n;
    logic chip_select_high_active;
    logic cs_oe_n;
    logic clock_out_select_pin;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [rtcnp_pkg::ADDR_W-1:0] reg_addr_in;
    logic [rtcnp_pkg::DATA_W-1:0] host_data_out;
    logic host_data_oe_n;
    // Device-driven pins
    logic [rtcnp_pkg::DATA_W-1:0] dev_data_out;
    logic dev_data_oe_n;
    logic clock_out_out;
    logic clock_out_oe_n;
    logic alarm_irq_out;
    logic alarm_irq_oe_n;
    logic timer_irq_out;
    logic timer_irq_oe_n;
    // Resolved levels
    logic cs_low_w;
    logic cs_high_w;
    logic [rtcnp_pkg::DATA_W-1:0] nibble_data_io;
    logic alarm_irq_n;
    logic timer_irq_n;
    logic clock_out_pin;

    // Pull-up on the low select, pull-down on the high select
    assign cs_low_w = cs_oe_n ? 1'b1 : chip_select_low_active_n;
    assign cs_high_w = cs_oe_n ? 1'b0 : chip_select_high_active;
    // Released bus reads as all ones (board pull-ups)
    assign nibble_data_io = !dev_data_oe_n ? dev_data_out :
                            (!host_data_oe_n ? host_data_out : 4'hF);
    assign alarm_irq_n = alarm_irq_oe_n ? 1'b1 : alarm_irq_out;
    assign timer_irq_n = timer_irq_oe_n ? 1'b1 : timer_irq_out;
    // Floating output shows low; check clock_out_oe_n for drive
    assign clock_out_pin = clock_out_oe_n ? 1'b0 : clock_out_out;

    modport host (
        output chip_select_low_active_n, chip_select_high_active, cs_oe_n,
        output clock_out_select_pin, read_strobe_n, write_strobe_n, reg_addr_in,
        output host_data_out, host_data_oe_n,
        input nibble_data_io, alarm_irq_n, timer_irq_n, clock_out_pin
    );

    modport dev (
        input cs_low_w, cs_high_w, clock_out_select_pin, read_strobe_n,
        input write_strobe_n, reg_addr_in, nibble_data_io,
        output dev_data_out, dev_data_oe_n, clock_out_out, clock_out_oe_n,
        output alarm_irq_out, alarm_irq_oe_n, timer_irq_out, timer_irq_oe_n
    );
endinterface

// [rtcnp_pkg.sv]
/*
  Constants, field layout and state encodings shared by both ends of the
  nibble-wide host port of a real-time clock.
  Assumes one 125 MHz system clock shared by both ends and a synchronous,
  active-high reset.
*/
// Behaviour
// - Access only when both chip selects active
// - High chip select alone enables clock output
// - Clock output floats while high select low
// - Select pin low gives fixed 32.768 kHz
// - Select pin high, enable set: chosen frequency
// - Host holds select pin high when idle (code drives it low whenever fixed_tone_i is set, idle or busy)
// - Selected read presents addressed register
// - Selected write stores data bus value
// - Host never drops both strobes together
// - Four-bit positive-logic address selects register
// - Data moves over four-bit bidirectional bus
// - Alarm interrupt output only pulls low
// - Timer interrupt output only pulls low
// - Undriven chip selects leave device deselected
package rtcnp_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 4;
    localparam int REG_NUM = 16;

    // ---------------------------------------------------------------
    // Register placement and fields
    // ---------------------------------------------------------------
    localparam logic [3:0] CTRL_ADDR = 4'hD;
    localparam logic [3:0] FLAG_ADDR = 4'hE;
    localparam logic [3:0] MASK_ADDR = 4'hF;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FD_LSB = 1;
    localparam int FD_W = 2;
    localparam int ALARM_BIT = 0;
    localparam int TIMER_BIT = 1;
    localparam logic [3:0] REG_RESET = 4'h0;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int TONE_HZ = 32_768;
    localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    localparam int TONE_CNT_W = 11;
    localparam int PRE_W = 15;
    localparam int STROBE_NS = 32;
    localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int STROBE_CNT_W = 4;

    // ---------------------------------------------------------------
    // Host sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        HS_IDLE = 5'b0_0001,
        HS_SETUP = 5'b0_0010,
        HS_STROBE = 5'b0_0100,
        HS_HOLD = 5'b0_1000,
        HS_DONE = 5'b1_0000
    } rtcnp_hstate_e;

endpackage

// [rtcnp_tb.sv]
/*
  Self-checking bench: host end and device end joined by the carrier.
  Assumes the device answers reads one cycle after the strobe and all
  inputs change at the falling clock edge.
*/
`timescale 1ns/1ns
module rtcnp_tb;
    localparam int HALF = 4;
    localparam int SEL = 0;
    localparam int ALM = 1;
    localparam int TMR = 2;
    localparam int CEN = 3;
    logic clk_i, reset_i, req_i, req_write_i, clk_out_on_i, fixed_tone_i;
    logic alarm_event_i, timer_event_i, ready_o, done_o, alarm_irq_o, timer_irq_o;
    logic selected_o, access_error_o, clk_out_enable_o;
    logic [3:0] req_addr_i, req_wdata_i, rdata_o, obs;
    logic [3:0] mem [16];
    logic [4:0] expq [$];
    logic [4:0] e;
    logic [31:0] seed;
    int failures, num_checks;

    rtcnp_if bus_if();
    rtcnp_dev #(.TONE_HALF(HALF)) u_rtcnp_dev (.clk_i(clk_i), .reset_i(reset_i),
        .bus(bus_if), .alarm_event_i(alarm_event_i), .timer_event_i(timer_event_i),
        .selected_o(selected_o), .access_error_o(access_error_o),
        .clk_out_enable_o(clk_out_enable_o));
    rtcnp_host u_rtcnp_host (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if),
        .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .clk_out_on_i(clk_out_on_i), .fixed_tone_i(fixed_tone_i),
        .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .alarm_irq_o(alarm_irq_o), .timer_irq_o(timer_irq_o));
    rtcnp_assertions #(.TONE_HALF(HALF)) u_rtcnp_assertions (.clk_i(clk_i),
        .reset_i(reset_i), .cs_low_w(bus_if.cs_low_w), .cs_high_w(bus_if.cs_high_w),
        .clock_out_select_pin(bus_if.clock_out_select_pin),
        .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
        .clock_out_out(bus_if.clock_out_out), .clock_out_oe_n(bus_if.clock_out_oe_n),
        .alarm_irq_out(bus_if.alarm_irq_out), .alarm_irq_oe_n(bus_if.alarm_irq_oe_n),
        .timer_irq_out(bus_if.timer_irq_out), .timer_irq_oe_n(bus_if.timer_irq_oe_n));
    assign obs = {clk_out_enable_o, timer_irq_o, alarm_irq_o, selected_o};

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check_data(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_data({3'h0, got}, {3'h0, exp});
    endtask

    task automatic print_verdict();
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Waits on ready under a bound; expectation queued before the request
    task automatic bus_op(input logic wr, input logic [3:0] addr, input logic [3:0] data,
                          input logic [3:0] exp);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 50)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 50)
            failures++;
        expq.push_back({!wr, exp});
        req_write_i = wr;
        req_addr_i = addr;
        req_wdata_i = data;
        req_i = 1'b1;
        @(negedge clk_i);
        req_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic expect_level(input int i, input logic lvl);
        int n;
        n = 0;
        while (obs[i] !== lvl && n < 12)
        begin
            @(negedge clk_i);
            n++;
        end
        check_bit(obs[i], lvl);
    endtask

    // Over 8 half periods exactly 8 edges, whatever the starting phase
    task automatic tone_check(input int h);
        logic prev;
        logic [3:0] cnt;
        cnt = 4'h0;
        prev = bus_if.clock_out_pin;
        repeat (8 * h)
        begin
            @(negedge clk_i);
            if (bus_if.clock_out_pin !== prev)
                cnt++;
            prev = bus_if.clock_out_pin;
        end
        check_data(cnt, 4'h8);
    endtask

    task automatic pulse_event(input logic [1:0] ev);
        {timer_event_i, alarm_event_i} = ev;
        @(negedge clk_i);
        {timer_event_i, alarm_event_i} = 2'b00;
    endtask

    // ---------------------------------------------------------------
    // Result monitor and watchdog
    // ---------------------------------------------------------------
    always @(negedge clk_i)
    begin
        if (done_o === 1'b1)
        begin
            if (expq.size() == 0)
                failures++;
            else
            begin
                e = expq.pop_front();
                if (e[4])
                    check_data(rdata_o, e[3:0]);
            end
        end
    end

    initial
    begin
        #(8 * 20000);
        failures++;
        print_verdict();
    end

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        reset_i = 1'b1;
        {req_i, req_write_i, req_addr_i, req_wdata_i} = 10'h000;
        {clk_out_on_i, fixed_tone_i, alarm_event_i, timer_event_i} = 4'b0000;
        seed = 32'h0677;
        failures = 0;
        num_checks = 0;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        expect_level(CEN, 1'b0);
        expect_level(SEL, 1'b0);
        for (int a = 0; a < 16; a++)
        begin
            seed = xs(seed);
            mem[a] = seed[3:0];
            clk_out_on_i = seed[4];
            if (a != 14)
                bus_op(1'b1, a[3:0], mem[a], 4'h0);
        end
        for (int a = 0; a < 16; a++)
            if (a != 14)
                bus_op(1'b0, a[3:0], 4'h0, mem[a]);
        clk_out_on_i = 1'b1;
        bus_op(1'b1, rtcnp_pkg::CTRL_ADDR, 4'h0, 4'h0);
        expect_level(SEL, 1'b1);
        expect_level(CEN, 1'b0);
        fixed_tone_i = 1'b1;
        expect_level(CEN, 1'b1);
        tone_check(HALF);
        fixed_tone_i = 1'b0;
        bus_op(1'b1, rtcnp_pkg::CTRL_ADDR, 4'h3, 4'h0);
        expect_level(CEN, 1'b1);
        tone_check(32 * HALF);
        clk_out_on_i = 1'b0;
        expect_level(CEN, 1'b0);
        bus_op(1'b1, rtcnp_pkg::MASK_ADDR, 4'h1, 4'h0);
        pulse_event(2'b01);
        expect_level(ALM, 1'b1);
        bus_op(1'b0, rtcnp_pkg::FLAG_ADDR, 4'h0, 4'h1);
        bus_op(1'b1, rtcnp_pkg::FLAG_ADDR, 4'h1, 4'h0);
        expect_level(ALM, 1'b0);
        pulse_event(2'b10);
        repeat (12) @(negedge clk_i);
        check_bit(timer_irq_o, 1'b0);
        bus_op(1'b0, rtcnp_pkg::FLAG_ADDR, 4'h0, 4'h2);
        bus_op(1'b1, rtcnp_pkg::MASK_ADDR, 4'h2, 4'h0);
        expect_level(TMR, 1'b1);
        bus_op(1'b1, rtcnp_pkg::FLAG_ADDR, 4'h2, 4'h0);
        expect_level(TMR, 1'b0);
        repeat (20) @(negedge clk_i);
        check_data({3'h0, access_error_o}, 4'h0);
        check_data(4'(expq.size()), 4'h0);
        print_verdict();
    end
endmodule
